/* File: include/ctf_params.svh */
// Register offsets, field positions and reset values of the tx channel
`ifndef CTF_PARAMS_SVH
`define CTF_PARAMS_SVH

// Register byte offsets (word aligned)
`define CTF_OFF_CHCFG     8'h00
`define CTF_OFF_PRESC     8'h04
`define CTF_OFF_ISTAT     8'h08
`define CTF_OFF_IMASK     8'h0c
`define CTF_OFF_TXREQ     8'h10
`define CTF_OFF_FCFG      8'h20
`define CTF_OFF_FSTAT     8'h30
`define CTF_OFF_FPUSH     8'h40
// Buffer storage window selector (address bit 9)
`define CTF_MEM_BIT       9

// Channel configuration fields
`define CTF_CH_MERGE      0
`define CTF_CH_RESET      1

// FIFO configuration fields
`define CTF_FC_EN         0
`define CTF_FC_IMODE      1
`define CTF_FC_MODE_LO    2
`define CTF_FC_MODE_HI    3
`define CTF_FC_RES        4
`define CTF_FC_SRC        5
`define CTF_FC_IEN        6
`define CTF_FC_LINK_LO    8
`define CTF_FC_LINK_HI    11
`define CTF_FC_IVL_LO     16
`define CTF_FC_IVL_HI     23
`define CTF_FC_MASK       32'h00ff0f7f

// FIFO status fields
`define CTF_FS_EMPTY      0
`define CTF_FS_FULL       1
`define CTF_FS_IFLAG      2
`define CTF_FS_CNT_LO     8

// Interrupt status bit of a finished buffer frame
`define CTF_IS_BUF        3
`define CTF_IRQ_W         4

// Buffer geometry: words per buffer, first data word, data words
`define CTF_BUF_WORDS     8
`define CTF_DATA_FIRST    3
`define CTF_SINGLE_WORDS  5
`define CTF_DIV_TEN       4'h9

// Reset values
`define CTF_RST_PRESC     16'h0001
`define CTF_RST_WORD      32'h00000000

`endif

/* File: include/ctf_pkg.sv */
// Types shared by the transmit channel and its interval timer
package ctf_pkg;

  // Arbiter / frame request states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_REQ,
    TX_BUSY
  } ctf_tx_st_t;

  // Operating mode of a tx/rx FIFO
  typedef enum logic [1:0] {
    FM_RX,
    FM_TX,
    FM_GW,
    FM_RSVD
  } ctf_fmode_t;

endpackage : ctf_pkg

/* File: rtl/ctf_ivl_timer.sv */
// Interval timer spacing consecutive sends of one FIFO
`timescale 1ns/100ps
`include "ctf_params.svh"
module ctf_ivl_timer
  import ctf_pkg::*;
(
  input  wire logic       clk,       // Peripheral clock
  input  wire logic       rst,       // Sync reset, high
  input  wire logic       ce,        // Clock enable
  input  wire logic       pre_tick,  // pclk/2/M pulse
  input  wire logic       bit_tick,  // Nominal bit-time pulse
  input  wire logic       res_ten,   // Extra divide by ten
  input  wire logic       src_bit,   // Count bit times
  input  wire logic [7:0] ivl,       // Interval N in ticks
  input  wire logic       run_ok,    // FIFO enabled, not in reset
  input  wire logic       start,     // Frame done at 7th EOF bit
  output logic            ready      // Next message may go
);

  logic       run_q;   // Interval is being timed
  logic [7:0] cnt_q;   // Ticks elapsed
  logic [3:0] dec_q;   // Divide-by-ten prescaler
  logic       tick;    // Selected count source

  // Bit clock ignores the resolution bit
  always_comb begin
    if (src_bit) begin
      tick = bit_tick;
    end else if (res_ten) begin
      tick = pre_tick & (dec_q == `CTF_DIV_TEN);
    end else begin
      tick = pre_tick;
    end
  end

  // Decade divider only runs while timing
  always_ff @(posedge clk) begin
    if (rst || (ce && (!run_ok || start))) begin
      dec_q <= 4'h0;
    end else if (ce && run_q && pre_tick) begin
      dec_q <= (dec_q == `CTF_DIV_TEN) ? 4'h0 : dec_q + 4'h1;
    end
  end

  // Timer starts at frame end, stops on disable or channel reset
  always_ff @(posedge clk) begin
    if (rst || (ce && !run_ok)) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (ce) begin
      if (start) begin
        run_q <= (ivl != 8'h00);
        cnt_q <= 8'h00;
      end else if (run_q && tick) begin
        // N ticks elapsed: release and reset the timer
        if (cnt_q + 8'h01 == ivl) begin
          run_q <= 1'b0;
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  // Only a running interval holds the FIFO back
  assign ready = ~run_q;

endmodule : ctf_ivl_timer

/* File: rtl/ctf_tx_channel.sv */
// Transmit side of one CAN FD channel: buffers, merge, tx FIFOs
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "ctf_params.svh"
module ctf_tx_channel
  import ctf_pkg::*;
#(
  parameter int NBUF  = 16,  // Transmit buffers per channel
  parameter int NFIFO = 3,   // Tx/rx FIFOs, at most 3
  parameter int DEPTH = 32   // Messages per FIFO
) (
  input  wire logic        clk,             // Peripheral clock
  input  wire logic        rst,             // Sync reset, high
  input  wire logic        ce,              // Clock enable
  input  wire logic [9:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read strobe
  input  wire logic        avs_write,       // Write strobe
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  output logic             irq,             // Level interrupt
  output logic             tx_req,          // Frame ready to send
  output logic [31:0]      tx_id,           // ID word
  output logic [31:0]      tx_ptr,          // Label and DLC word
  output logic [31:0]      tx_fdctrl,       // ESI/BRS/FDF word
  output logic             tx_merged,       // 64-byte payload
  output logic [3:0]       tx_link,         // Buffer used
  input  wire logic        eng_ack,         // Engine took frame
  input  wire logic        eng_ok,          // Done, 7th EOF bit
  input  wire logic        eng_fail,        // Lost or error
  input  wire logic [3:0]  eng_rd_idx,      // Payload word index
  output logic [31:0]      eng_rd_data,     // Payload word
  input  wire logic        bit_tick         // Nominal bit pulse
);

  localparam int AW = $clog2(DEPTH);
  localparam int MW = $clog2(NBUF * `CTF_BUF_WORDS);

  // Payload storage of merged sets; write mask
  function automatic logic is_payload(input logic [3:0] b,
                                      input logic       mrg);
    is_payload = mrg & ((b == 4'h1) | (b == 4'h2) |
                        (b == 4'h4) | (b == 4'h5));
  endfunction : is_payload

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : be_merge

  // Payload word index to storage word: a merged set is linear
  function automatic logic [MW:0] pay_addr(input logic [3:0] base,
                                           input logic [3:0] idx,
                                           input logic       mrg);
    logic [MW+1:0] a;
    a = (MW+2)'(base) * (MW+2)'(`CTF_BUF_WORDS)
      + (MW+2)'(`CTF_DATA_FIRST) + (MW+2)'(idx);
    pay_addr = {mrg | (idx < 4'(`CTF_SINGLE_WORDS)), a[MW-1:0]};
  endfunction : pay_addr

  // Bus handshake
  logic              ack_q;       // Second cycle of an access
  logic [31:0]       rdata_q;     // Read data
  logic              wr_go;       // Write takes effect now
  logic              rd_go;       // Read data captured now
  logic [7:0]        roff;        // Register byte offset
  logic              in_mem;      // Buffer storage window
  logic [MW-1:0]     maddr;       // Storage word address
  // Control and status
  logic              merge_q;     // Merge mode enable
  logic              creset_q;    // Channel reset mode
  logic [15:0]       presc_q;     // Interval prescaler M
  logic [`CTF_IRQ_W-1:0] istat_q; // Sticky events
  logic [`CTF_IRQ_W-1:0] imask_q; // Event enables
  logic [NBUF-1:0]   txreq_q;     // Pending buffer requests
  logic [31:0]       fcfg_q [NFIFO];         // FIFO configuration
  logic [31:0]       bmem  [NBUF*`CTF_BUF_WORDS]; // Buffer words
  logic [31:0]       fmem  [NFIFO*DEPTH];    // FIFO message words
  logic [AW-1:0]     wp_q  [NFIFO];          // Write pointers
  logic [AW-1:0]     rp_q  [NFIFO];          // Read pointers
  logic [AW:0]       fcnt_q [NFIFO];         // Fill counts
  // Transmit arbiter
  ctf_tx_st_t        st_q;        // Request state
  logic              cur_fifo_q;  // Frame came from a FIFO
  logic [3:0]        cur_idx_q;   // Buffer or FIFO number
  logic [NFIFO-1:0]  f_en;        // FIFO enable bits
  logic [NFIFO-1:0]  f_cand;      // FIFO head may compete
  logic [NFIFO-1:0]  f_ready;     // Interval elapsed
  logic [NFIFO-1:0]  f_done;      // FIFO frame finished
  logic [NFIFO-1:0]  f_push;      // Accepted push
  logic              buf_done;    // Buffer frame finished
  logic              done;        // Any frame finished
  logic [NBUF-1:0]   b_cand;      // Buffers that may compete
  logic              pick_any;    // Something to send
  logic              pick_fifo;   // Winner is a FIFO
  logic [3:0]        pick_idx;    // Winner number
  logic [3:0]        pick_base;   // Buffer whose words are sent
  // Interval prescaler
  logic              half_q;      // pclk/2 phase
  logic [15:0]       pcnt_q;      // Divide-by-M counter
  logic              pre_tick;    // pclk/2/M pulse

  // One wait state on every access, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign wr_go  = avs_write & ack_q;
  assign rd_go  = avs_read & ~ack_q;
  assign roff   = avs_address[7:0];
  assign in_mem = avs_address[`CTF_MEM_BIT];
  assign maddr  = avs_address[MW+1:2];

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // FIFO enables and who may compete
  always_comb begin
    for (int k = 0; k < NFIFO; k++) begin
      f_en[k]   = fcfg_q[k][`CTF_FC_EN];
      // Transmit and gateway FIFOs send, receive FIFOs never
      f_cand[k] = f_en[k] & ~creset_q & (fcnt_q[k] != '0) & f_ready[k]
        & ((fcfg_q[k][`CTF_FC_MODE_HI:`CTF_FC_MODE_LO] == 2'(FM_TX)) |
           (fcfg_q[k][`CTF_FC_MODE_HI:`CTF_FC_MODE_LO] == 2'(FM_GW)));
      f_push[k] = wr_go & ~in_mem & (roff == `CTF_OFF_FPUSH + 8'(4*k))
                & f_en[k] & (fcnt_q[k] != (AW+1)'(DEPTH));
    end
    for (int b = 0; b < NBUF; b++) begin
      b_cand[b] = txreq_q[b] & ~is_payload(4'(b), merge_q);
    end
  end

  // Fixed priority: lowest buffer, then lowest FIFO head
  always_comb begin
    pick_any  = 1'b0;
    pick_fifo = 1'b0;
    pick_idx  = 4'h0;
    pick_base = 4'h0;
    for (int k = NFIFO - 1; k >= 0; k--) begin
      if (f_cand[k]) begin
        pick_any  = 1'b1;
        pick_fifo = 1'b1;
        pick_idx  = 4'(k);
        pick_base = fcfg_q[k][`CTF_FC_LINK_HI:`CTF_FC_LINK_LO];
      end
    end
    for (int b = NBUF - 1; b >= 0; b--) begin
      if (b_cand[b]) begin
        pick_any  = 1'b1;
        pick_fifo = 1'b0;
        pick_idx  = 4'(b);
        pick_base = 4'(b);
      end
    end
  end

  // Completion pulses from the protocol engine
  assign done     = (st_q == TX_BUSY) & eng_ok;
  assign buf_done = done & ~cur_fifo_q;
  always_comb begin
    for (int k = 0; k < NFIFO; k++) begin
      f_done[k] = done & cur_fifo_q & (cur_idx_q == 4'(k));
    end
  end

  // Frame request sequence; a failed frame simply competes again
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q       <= TX_IDLE;
      cur_fifo_q <= 1'b0;
      cur_idx_q  <= 4'h0;
      tx_id      <= `CTF_RST_WORD;
      tx_ptr     <= `CTF_RST_WORD;
      tx_fdctrl  <= `CTF_RST_WORD;
      tx_merged  <= 1'b0;
      tx_link    <= 4'h0;
    end else if (ce) begin
      case (st_q)
        TX_IDLE: begin
          if (pick_any && !creset_q) begin
            st_q       <= TX_REQ;
            cur_fifo_q <= pick_fifo;
            cur_idx_q  <= pick_idx;
            tx_link    <= pick_base;
            tx_merged  <= ~pick_fifo & merge_q &
                          ((pick_idx == 4'h0) | (pick_idx == 4'h3));
            // FIFO supplies the ID; header rest from the buffer
            tx_id      <= pick_fifo
              ? fmem[pick_idx[1:0]*DEPTH + int'(rp_q[pick_idx[1:0]])]
              : bmem[pick_base*`CTF_BUF_WORDS];
            tx_ptr     <= bmem[pick_base*`CTF_BUF_WORDS + 1];
            tx_fdctrl  <= bmem[pick_base*`CTF_BUF_WORDS + 2];
          end
        end
        TX_REQ: begin
          if (eng_ack) begin
            st_q <= TX_BUSY;
          end else if (creset_q || (cur_fifo_q && !f_en[cur_idx_q[1:0]]))
          begin
            st_q <= TX_IDLE;
          end
        end
        TX_BUSY: begin
          // Frame on the bus finishes even if its FIFO was aborted
          if (eng_ok || eng_fail) begin
            st_q <= TX_IDLE;
          end
        end
        default: begin
          st_q <= TX_IDLE;
        end
      endcase
    end
  end
  assign tx_req = (st_q == TX_REQ);

  // Payload words for the engine, merged sets read across buffers
  always_ff @(posedge clk) begin
    logic [MW:0] pa;
    pa = pay_addr(tx_link, eng_rd_idx, tx_merged);
    if (rst) begin
      eng_rd_data <= `CTF_RST_WORD;
    end else if (ce) begin
      eng_rd_data <= pa[MW] ? bmem[pa[MW-1:0]] : `CTF_RST_WORD;
    end
  end

  // Buffer word storage, written through the bus window
  always_ff @(posedge clk) begin
    if (ce && wr_go && in_mem) begin
      bmem[maddr] <= be_merge(bmem[maddr], avs_writedata, avs_byteenable);
    end
  end

  // Channel control, prescaler and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      merge_q  <= 1'b0;
      creset_q <= 1'b0;
      presc_q  <= `CTF_RST_PRESC;
      imask_q  <= '0;
    end else if (ce && wr_go && !in_mem) begin
      case (roff)
        `CTF_OFF_CHCFG: begin
          merge_q  <= avs_writedata[`CTF_CH_MERGE];
          creset_q <= avs_writedata[`CTF_CH_RESET];
        end
        `CTF_OFF_PRESC: presc_q <= avs_writedata[15:0];
        `CTF_OFF_IMASK: imask_q <= avs_writedata[`CTF_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // FIFO configuration words
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NFIFO; k++) begin
        fcfg_q[k] <= `CTF_RST_WORD;
      end
    end else if (ce && wr_go && !in_mem) begin
      for (int k = 0; k < NFIFO; k++) begin
        if (roff == `CTF_OFF_FCFG + 8'(4*k)) begin
          fcfg_q[k] <= be_merge(fcfg_q[k], avs_writedata,
                                avs_byteenable) & `CTF_FC_MASK;
        end
      end
    end
  end

  // Buffer requests: payload buffers of a set never request
  always_ff @(posedge clk) begin
    if (rst) begin
      txreq_q <= '0;
    end else if (ce) begin
      for (int b = 0; b < NBUF; b++) begin
        if (wr_go && !in_mem && roff == `CTF_OFF_TXREQ &&
            avs_writedata[b] && !is_payload(4'(b), merge_q)) begin
          txreq_q[b] <= 1'b1;
        end else if (creset_q || (buf_done && cur_idx_q == 4'(b))) begin
          txreq_q[b] <= 1'b0;
        end
      end
    end
  end

  // FIFO pointers: disable empties the whole FIFO at once
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NFIFO; k++) begin
        wp_q[k]   <= '0;
        rp_q[k]   <= '0;
        fcnt_q[k] <= '0;
      end
    end else if (ce) begin
      for (int k = 0; k < NFIFO; k++) begin
        if (!f_en[k]) begin
          wp_q[k]   <= '0;
          rp_q[k]   <= '0;
          fcnt_q[k] <= '0;
        end else begin
          if (f_push[k]) begin
            fmem[k*DEPTH + int'(wp_q[k])] <= avs_writedata;
            wp_q[k] <= wp_q[k] + 1'b1;
          end
          if (f_done[k]) begin
            rp_q[k] <= rp_q[k] + 1'b1;
          end
          fcnt_q[k] <= fcnt_q[k] + (AW+1)'(f_push[k])
                     - (AW+1)'(f_done[k]);
        end
      end
    end
  end

  // Sticky events, cleared by writing one; a new event wins
  always_ff @(posedge clk) begin
    logic [`CTF_IRQ_W-1:0] set;
    logic [`CTF_IRQ_W-1:0] clr;
    set = '0;
    clr = '0;
    for (int k = 0; k < NFIFO; k++) begin
      // Every message, or only the one that leaves it empty
      set[k] = f_done[k] & fcfg_q[k][`CTF_FC_IEN] &
               (fcfg_q[k][`CTF_FC_IMODE] | !f_en[k] |
                (fcnt_q[k] == (AW+1)'(1)));
    end
    set[`CTF_IS_BUF] = buf_done;
    if (wr_go && !in_mem && roff == `CTF_OFF_ISTAT) begin
      clr = avs_writedata[`CTF_IRQ_W-1:0];
    end
    if (rst) begin
      istat_q <= '0;
    end else if (ce) begin
      istat_q <= (istat_q & ~clr) | set;
    end
  end
  assign irq = |(istat_q & imask_q);

  // Shared prescaler: pclk halved, then divided by M
  always_ff @(posedge clk) begin
    if (rst) begin
      half_q <= 1'b0;
      pcnt_q <= 16'h0000;
    end else if (ce) begin
      half_q <= ~half_q;
      if (half_q) begin
        pcnt_q <= pre_tick ? 16'h0000 : pcnt_q + 16'h0001;
      end
    end
  end
  assign pre_tick = half_q & ((pcnt_q + 16'h0001 >= presc_q) |
                              (presc_q == 16'h0000));

  // One interval timer per FIFO
  for (genvar k = 0; k < NFIFO; k++) begin : g_ivl
    ctf_ivl_timer u_ivl (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .pre_tick (pre_tick),
      .bit_tick (bit_tick),
      .res_ten  (fcfg_q[k][`CTF_FC_RES]),
      .src_bit  (fcfg_q[k][`CTF_FC_SRC]),
      .ivl      (fcfg_q[k][`CTF_FC_IVL_HI:`CTF_FC_IVL_LO]),
      .run_ok   (f_en[k] & ~creset_q),
      .start    (f_done[k]),
      .ready    (f_ready[k])
    );
  end

  // Read data, captured in the first cycle of an access
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `CTF_RST_WORD;
    end else if (ce && rd_go) begin
      rdata_q <= `CTF_RST_WORD;
      if (in_mem) begin
        rdata_q <= bmem[maddr];
      end else begin
        case (roff)
          `CTF_OFF_CHCFG: rdata_q <= {30'h0, creset_q, merge_q};
          `CTF_OFF_PRESC: rdata_q <= {16'h0, presc_q};
          `CTF_OFF_ISTAT: rdata_q <= 32'(istat_q);
          `CTF_OFF_IMASK: rdata_q <= 32'(imask_q);
          `CTF_OFF_TXREQ: rdata_q <= 32'(txreq_q);
          default: begin
            for (int k = 0; k < NFIFO; k++) begin
              if (roff == `CTF_OFF_FCFG + 8'(4*k)) begin
                rdata_q <= fcfg_q[k];
              end
              if (roff == `CTF_OFF_FSTAT + 8'(4*k)) begin
                rdata_q[`CTF_FS_EMPTY] <= (fcnt_q[k] == '0);
                rdata_q[`CTF_FS_FULL]  <= (fcnt_q[k] == (AW+1)'(DEPTH));
                rdata_q[`CTF_FS_IFLAG] <= istat_q[k];
                rdata_q[`CTF_FS_CNT_LO +: AW+1] <= fcnt_q[k];
              end
            end
          end
        endcase
      end
    end
  end

endmodule : ctf_tx_channel

/* File: bench/ctf_tx_channel_assertions.sv */
// Port checker of the transmit channel
`timescale 1ns/100ps
module ctf_tx_channel_chk (
  input wire logic        clk,             // Clock
  input wire logic        rst,             // Reset
  input wire logic        avs_read,        // Read
  input wire logic        avs_write,       // Write
  input wire logic        avs_waitrequest, // Stall
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        irq,             // Interrupt
  input wire logic        tx_req,          // Offer
  input wire logic [31:0] tx_id,           // Header
  input wire logic        tx_merged,       // Merged
  input wire logic [3:0]  tx_link,         // Source
  input wire logic        eng_ack,         // Taken
  input wire logic        eng_ok,          // Done
  input wire logic [3:0]  eng_rd_idx,      // Index
  input wire logic [31:0] eng_rd_data      // Word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // One wait state, then the answer
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  idle_nostall_a: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest) else $error("stall without request");
  // Read data stands in the cycle after a read ends
  rdata_hold_a: assert property (avs_read && !avs_waitrequest ##1 !avs_read
    |-> $stable(avs_readdata)) else $error("read data moved");
  // Own disable, so reset is seen
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !tx_req && !irq)
    else $error("outputs busy after reset");
  hdr_hold_a: assert property (tx_req ##1 tx_req |-> $stable(tx_id))
    else $error("header moved while offered");
  merge_head_a: assert property (tx_req && tx_merged
    |-> tx_link == 4'h0 || tx_link == 4'h3) else $error("merged not first");
  pad_zero_a: assert property (!tx_merged && eng_rd_idx > 4'h4
    |=> eng_rd_data == 32'h0) else $error("single frame too long");
  busy_quiet_a: assert property (tx_req && eng_ack |=> !tx_req)
    else $error("offer while busy");
  idle_gap_a: assert property (eng_ok && !tx_req |=> !tx_req)
    else $error("offer right after finish");
  // Main scenarios
  merged_c: cover property (tx_req && tx_merged);
  done_c: cover property (eng_ok);
  irq_c: cover property ($rose(irq));
endmodule : ctf_tx_channel_chk
bind ctf_tx_channel ctf_tx_channel_chk chk_u (.*);

/* File: bench/ctf_eng_model.sv */
// Behavioural CAN engine on the bus side of the channel
`timescale 1ns/100ps
module ctf_eng_model (
  input  wire logic        clk,                // Clock
  input  wire logic        rst,                // Reset
  input  wire logic        tx_req,             // Offer
  input  wire logic [31:0] tx_id,              // Header
  input  wire logic [31:0] eng_rd_data,        // Payload word
  input  wire logic [7:0]  slow,               // Delay before taking
  output logic             eng_ack = 1'b0,     // Taken
  output logic             eng_ok = 1'b0,      // Finished
  output logic             eng_fail,           // Never lost here
  output logic [3:0]       eng_rd_idx = 4'h0,  // Index
  output logic             bit_tick = 1'b0,    // Bit time
  output logic [7:0]       done_cnt = 8'h0     // Frames done
);
  logic [31:0] pay [16];      // Last payload
  logic [31:0] id_log [32];   // Headers in send order
  logic [15:0] glog [32];     // Gap before each frame
  logic [15:0] gap = 16'h0;   // Since last finish
  logic [7:0]  wt = 8'h0;     // Offer wait
  logic [4:0]  i = 5'h0;      // Fetch step
  logic [2:0]  bt = 3'h0;     // Bit divider
  logic        busy = 1'b0;   // Frame on bus
  assign eng_fail = 1'b0;
  // One bit time per eight cycles
  always @(posedge clk) begin
    bt <= rst ? 3'h0 : bt + 3'h1;
    bit_tick <= (bt == 3'h7) && !rst;
  end
  // Take an offer, fetch sixteen words, finish
  always @(posedge clk) begin
    eng_ack <= 1'b0;
    eng_ok <= 1'b0;
    gap <= gap + 16'h1;
    if (rst) begin
      busy <= 1'b0;
      done_cnt <= 8'h0;
    end else if (!busy) begin
      wt <= tx_req ? wt + 8'h1 : 8'h0;
      if (tx_req && wt >= slow) begin
        eng_ack <= 1'b1;
        busy <= 1'b1;
        i <= 5'h0;
        id_log[done_cnt[4:0]] <= tx_id;
        glog[done_cnt[4:0]] <= gap;
      end
    end else begin
      // Data comes one cycle after its index
      eng_rd_idx <= i[3:0];
      i <= i + 5'h1;
      if (i >= 5'h2) pay[i-5'h2] <= eng_rd_data;
      if (i == 5'h11) begin
        eng_ok <= 1'b1;
        busy <= 1'b0;
        done_cnt <= done_cnt + 8'h1;
        gap <= 16'h0;
      end
    end
  end
endmodule : ctf_eng_model

/* File: bench/test_can_fd_tx_merge_fifo_interval.sv */
// Self-checking bench of the transmit channel
`timescale 1ns/100ps
`include "ctf_params.svh"
module test_can_fd_tx_merge_fifo_interval;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;  // Clock, reset, enable
  logic [9:0] avs_address = 10'h0;           // Address
  logic avs_read = 1'b0, avs_write = 1'b0;   // Strobes
  logic [31:0] avs_writedata = 32'h0, rv;    // Write data, last read
  logic [3:0] avs_byteenable = 4'hf;         // All lanes
  logic [31:0] avs_readdata, tx_id, tx_ptr, tx_fdctrl, eng_rd_data;
  logic avs_waitrequest, irq, tx_req, tx_merged, eng_ack, eng_ok, eng_fail;
  logic bit_tick;                            // Bit time
  logic [3:0] tx_link, eng_rd_idx;           // Indices
  logic [7:0] slow = 8'h0, done_cnt;         // Engine delay, frames
  int bad_count = 0, n_checks = 0;           // Counters
  logic [7:0] d0;                            // Frames before a test
  ctf_tx_channel dut_u (.*);
  ctf_eng_model eng_u (.*);
  initial forever #4 clk = ~clk;
  // Hang guard
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
  // Held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask : acc
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    acc(1'b0, a, 32'h0);
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Bounded wait for n frames
  task automatic wait_done(input logic [7:0] n);
    repeat (3000) if (done_cnt != n) @(posedge clk);
    @(negedge clk);
    chk(done_cnt, n);
  endtask : wait_done
  task automatic t_regs();
    rd(`CTF_OFF_PRESC); chk(rv, {16'h0, `CTF_RST_PRESC});
    rd(`CTF_OFF_FSTAT); chk(rv[0], 1);
    wr(10'h0fc, 32'hffffffff);
    rd(10'h0fc); chk(rv, 0);
    $display("regs done");
  endtask : t_regs
  // Buffer frame, irq mask and clear
  task automatic t_buf();
    d0 = done_cnt;
    for (int w = 0; w < 8; w++) wr(10'h220 + 10'(4*w), 32'hb1000000 + w);
    wr(`CTF_OFF_IMASK, 32'h8);
    wr(`CTF_OFF_TXREQ, 32'h2);
    wait_done(d0 + 8'h1);
    chk(eng_u.id_log[d0[4:0]], 32'hb1000000);
    for (int k = 0; k < 6; k++)
      chk(eng_u.pay[k], k < 5 ? 32'hb1000003 + k : 0);
    chk(irq, 1);
    wr(`CTF_OFF_IMASK, 32'h0);
    chk(irq, 0);
    wr(`CTF_OFF_ISTAT, 32'h8);
    rd(`CTF_OFF_ISTAT); chk(rv, 0);
    $display("buffer done");
  endtask : t_buf
  task automatic t_merge();
    d0 = done_cnt;
    wr(`CTF_OFF_CHCFG, 32'h1);
    for (int s = 24; s < 48; s++) wr(10'h200 + 10'(4*s), 32'h5a000000 + s);
    wr(`CTF_OFF_TXREQ, 32'h8);
    wait_done(d0 + 8'h1);
    chk(eng_u.id_log[d0[4:0]], 32'h5a000018);
    for (int k = 0; k < 16; k++) chk(eng_u.pay[k], 32'h5a00001b + k);
    wr(`CTF_OFF_CHCFG, 32'h0);
    wr(`CTF_OFF_ISTAT, 32'hf);
    $display("merge done");
  endtask : t_merge
  // Three messages via buffer 7
  task automatic t_fifo(input int f, input logic [31:0] cfg, m,
                        input int lo, hi);
    d0 = done_cnt;
    wr(`CTF_OFF_PRESC, m);
    wr(`CTF_OFF_FCFG + 8'(4*f), cfg);
    for (int k = 0; k < 3; k++) wr(`CTF_OFF_FPUSH + 8'(4*f), 32'hc0 + k);
    wait_done(d0 + 8'h1);
    rd(`CTF_OFF_ISTAT);
    chk(rv[f], cfg[1]);
    wait_done(d0 + 8'h3);
    for (int k = 0; k < 3; k++)
      chk(eng_u.id_log[d0+k], 32'hc0 + k);
    for (int k = 1; k < 3; k++)
      chk(eng_u.glog[d0+k] inside {[lo:hi]}, 1);
    rd(`CTF_OFF_ISTAT); chk(rv[f], 1);
    wr(`CTF_OFF_FCFG + 8'(4*f), 32'h0);
    wr(`CTF_OFF_ISTAT, 32'h7);
    $display("fifo %0d done", f);
  endtask : t_fifo
  // Disable while the head waits for the bus
  task automatic t_abort();
    d0 = done_cnt;
    slow <= 8'hc8;
    wr(`CTF_OFF_FCFG, 32'h00000765);
    for (int k = 0; k < 3; k++) wr(`CTF_OFF_FPUSH, 32'hd0 + k);
    wr(`CTF_OFF_FCFG, 32'h00000764);
    rd(`CTF_OFF_FSTAT); chk(rv[15:0], 16'h0001);
    rd(`CTF_OFF_ISTAT); chk(rv, 0);
    chk(done_cnt, d0);
    slow <= 8'h0;
    $display("abort done");
  endtask : t_abort
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_buf();
    t_merge();
    t_fifo(0, 32'h00040765, 32'h1, 24, 40);
    t_fifo(1, 32'h00040745, 32'h3, 18, 32);
    t_fifo(2, 32'h00020755, 32'h1, 20, 48);
    t_fifo(0, 32'h0004076b, 32'h1, 24, 40);
    t_abort();
    complete_run();
  end
endmodule : test_can_fd_tx_merge_fifo_interval
